// ### bst_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module bst_ctrl_model (
  output var bst_pkg::bst_link_in_t link,
  input wire bst_pkg::bst_link_out_t lo
);
  import bst_pkg::*;
  logic seen;
  initial link = '0;
  // test clock idles low between calls, no free-running clock
  task automatic tick(input logic tms, input logic tdi);
    link.tms = tms;
    link.tdi = tdi;
    #62.5 link.tck = 1'b1;
    // an undriven line reads as the inverse, so a missed enable cannot pass
    #62 seen = lo.tdo_oe ? lo.tdo : ~lo.tdo;
    #0.5 link.tck = 1'b0;
  endtask
  // data line toggles outside shifts so a stale value cannot pass
  task automatic go(input logic [7:0] tms, input int n);
    for (int i = 0; i < n; i++)
      tick(tms[i], ~link.tdi);
  endtask
  // step off the clock edge so pin changes never race the samplers
  task automatic reset_tap();
    #1;
    go(8'h1F, 6);
  endtask
  task automatic shift(input int n, input logic [BSR_LEN-1:0] d, output logic [BSR_LEN-1:0] q);
    q = '0;
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, d[i]);
      q[i] = seen;
    end
    go(8'h01, 2);
  endtask
  task automatic ir(input logic [IR_LEN-1:0] code, output logic [BSR_LEN-1:0] q);
    #1;
    go(8'h03, 4);
    shift(IR_LEN, BSR_LEN'(code), q);
  endtask
  // config data goes in as plain data shifts
  task automatic dr(input int n, input logic [BSR_LEN-1:0] d, output logic [BSR_LEN-1:0] q);
    #1;
    go(8'h01, 3);
    shift(n, d, q);
  endtask
endmodule
`default_nettype wire

// ### bst_pkg.sv
`default_nettype none
package bst_pkg;
  localparam int IR_LEN = 10;
  localparam int BSR_LEN = 1164;
  localparam int DR32_LEN = 32;
  localparam int PROBE_LEN = 32;
  localparam int SYNC_W = 3;

  // instruction codes; all-ones is bypass, all-zeros external test
  localparam logic [IR_LEN-1:0] OP_EXTEST = 10'h000;
  localparam logic [IR_LEN-1:0] OP_SAMPLE = 10'h005;
  localparam logic [IR_LEN-1:0] OP_IDCODE = 10'h006;
  localparam logic [IR_LEN-1:0] OP_USERCODE = 10'h007;
  localparam logic [IR_LEN-1:0] OP_CFG_LOAD = 10'h002;
  localparam logic [IR_LEN-1:0] OP_PROBE = 10'h00E;
  localparam logic [IR_LEN-1:0] OP_BYPASS = 10'h3FF;
  localparam logic [IR_LEN-1:0] IR_CAPTURE_VAL = 10'h001;

  // identification fields; values are arbitrary
  localparam logic [3:0] ID_VERSION = 4'h1;
  localparam logic [15:0] ID_PART = 16'hA5C3;
  localparam logic [10:0] ID_MAKER = 11'h2B3;
  localparam logic ID_FIXED_BIT = 1'h1;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } bst_link_in_t;

  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } bst_link_out_t;

  typedef enum logic [15:0] {
    ST_RESET = 16'h0001,
    ST_IDLE = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SH_DR = 16'h0010,
    ST_EX1_DR = 16'h0020,
    ST_PAU_DR = 16'h0040,
    ST_EX2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SH_IR = 16'h0800,
    ST_EX1_IR = 16'h1000,
    ST_PAU_IR = 16'h2000,
    ST_EX2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } bst_state_t;

  typedef enum logic [2:0] {
    SEL_BYP = 3'h0,
    SEL_BSR = 3'h1,
    SEL_ID = 3'h2,
    SEL_USER = 3'h3,
    SEL_PROBE = 3'h4,
    SEL_CFG = 3'h5
  } bst_sel_t;
endpackage
`default_nettype wire

// ### bst_props.sv
`timescale 1ns/1ps
`default_nettype none
module bst_props (
  input wire logic clk,
  input wire logic srst,
  input wire bst_pkg::bst_link_in_t link_in,
  input wire bst_pkg::bst_link_out_t link_out,
  input wire logic config_busy,
  input wire logic [bst_pkg::BSR_LEN-1:0] core_out,
  input wire logic [bst_pkg::BSR_LEN-1:0] pin_out,
  input wire logic extest_active,
  input wire logic cfg_bit,
  input wire logic cfg_bit_valid
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  a_rst_quiet: assert property (disable iff (1'b0)
    srst |=> !extest_active && !cfg_bit_valid && link_out == '0 && pin_out == '0)
    else $error("outputs live in reset");
  a_busy_blocks: assert property (config_busy |=> !extest_active)
    else $error("pins held while configuring");
  a_ext_start: assert property ($rose(extest_active) |-> !$past(config_busy))
    else $error("external test began while busy");
  a_core_pass: assert property (
    !extest_active && !$past(srst) |-> pin_out == $past(core_out))
    else $error("pins disturbed outside external test");
  // margin of two clocks: sync delay may wander by one
  a_tdo_on_fall: assert property ($changed(link_out) |-> !$past(link_in.tck, 2))
    else $error("serial out moved while test clock high");
  a_cfg_single: assert property (cfg_bit_valid |=> !cfg_bit_valid [*8])
    else $error("config strobe too long");
  a_cfg_data: assert property (cfg_bit_valid |-> cfg_bit == $past(link_in.tdi, 3))
    else $error("config bit differs from serial in");
  a_cfg_in_shift: assert property (cfg_bit_valid |-> link_out.tdo_oe)
    else $error("config strobe outside shift");
  c_cfg: cover property (cfg_bit_valid);
  c_ext: cover property ($rose(extest_active));
  c_oe: cover property ($rose(link_out.tdo_oe));
endmodule
`default_nettype wire

// ### bst_sync.sv
`timescale 1ns/1ps
`default_nettype none
module bst_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end
    else
    begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a bit moves only once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clk)
      begin
        if (srst)
          q[i] <= 1'b0;
        else if (s2[i] == s3[i])
          q[i] <= s3[i];
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ### bst_tap.sv
`timescale 1ns/1ps
`default_nettype none
module bst_tap (
  input wire logic clk,
  input wire logic srst,
  input wire bst_pkg::bst_link_in_t link_in,
  output bst_pkg::bst_link_out_t link_out,
  input wire logic config_busy,
  input wire logic [bst_pkg::DR32_LEN-1:0] usercode,
  input wire logic [bst_pkg::PROBE_LEN-1:0] probe,
  input wire logic [bst_pkg::BSR_LEN-1:0] pin_in,
  input wire logic [bst_pkg::BSR_LEN-1:0] core_out,
  output logic [bst_pkg::BSR_LEN-1:0] pin_out,
  output logic extest_active,
  output logic cfg_bit,
  output logic cfg_bit_valid
);
  import bst_pkg::*;

  bst_link_in_t link_s;
  logic [BSR_LEN-1:0] pin_s;
  logic tck_prev;
  logic tck_rise;
  logic tck_fall;
  bst_state_t state;
  bst_state_t next_state;
  logic [IR_LEN-1:0] ir_shift;
  logic [IR_LEN-1:0] instr;
  bst_sel_t sel;
  logic bypass_bit;
  logic [DR32_LEN-1:0] dr32;
  logic [BSR_LEN-1:0] bsr_shift;
  logic [BSR_LEN-1:0] bsr_update;
  logic boundary_ok;
  logic serial_out;

  bst_sync #(
    .W(SYNC_W)
  ) u_link_sync (
    .clk(clk),
    .srst(srst),
    .d(link_in),
    .q(link_s)
  );

  bst_sync #(
    .W(BSR_LEN)
  ) u_pin_sync (
    .clk(clk),
    .srst(srst),
    .d(pin_in),
    .q(pin_s)
  );

  always_ff @(posedge clk)
  begin
    if (srst)
      tck_prev <= 1'b0;
    else
      tck_prev <= link_s.tck;
  end

  assign tck_rise = link_s.tck & ~tck_prev;
  assign tck_fall = ~link_s.tck & tck_prev;

  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_RESET:
        next_state = link_s.tms ? ST_RESET : ST_IDLE;
      ST_IDLE:
        next_state = link_s.tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR:
        next_state = link_s.tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR:
        next_state = link_s.tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:
        next_state = link_s.tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR:
        next_state = link_s.tms ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR:
        next_state = link_s.tms ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR:
        next_state = link_s.tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR:
        next_state = link_s.tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR:
        next_state = link_s.tms ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR:
        next_state = link_s.tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:
        next_state = link_s.tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR:
        next_state = link_s.tms ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR:
        next_state = link_s.tms ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR:
        next_state = link_s.tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR:
        next_state = link_s.tms ? ST_SEL_DR : ST_IDLE;
      default:
        next_state = ST_RESET;
    endcase
  end

  // moves only on a sampled rising test clock edge
  always_ff @(posedge clk)
  begin
    if (srst)
      state <= ST_RESET;
    else if (tck_rise)
      state <= next_state;
  end

  // instruction register
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ir_shift <= IR_CAPTURE_VAL;
      instr <= OP_IDCODE;
    end
    else if (tck_rise)
    begin
      unique case (state)
        ST_RESET:
          instr <= OP_IDCODE;
        ST_CAP_IR:
          ir_shift <= IR_CAPTURE_VAL;
        ST_SH_IR:
          ir_shift <= {link_s.tdi, ir_shift[IR_LEN-1:1]};
        ST_UPD_IR:
          instr <= ir_shift;
        default:
          instr <= instr;
      endcase
    end
  end

  // boundary codes are refused while configuration runs
  assign boundary_ok = ~config_busy;

  always_comb
  begin
    unique case (instr)
      OP_EXTEST:
        sel = boundary_ok ? SEL_BSR : SEL_BYP;
      OP_SAMPLE:
        sel = boundary_ok ? SEL_BSR : SEL_BYP;
      OP_IDCODE:
        sel = SEL_ID;
      OP_USERCODE:
        sel = SEL_USER;
      OP_CFG_LOAD:
        sel = SEL_CFG;
      OP_PROBE:
        sel = SEL_PROBE;
      default:
        sel = SEL_BYP;
    endcase
  end

  // one-bit path, captured as zero
  always_ff @(posedge clk)
  begin
    if (srst)
      bypass_bit <= 1'b0;
    else if (tck_rise && state == ST_CAP_DR)
      bypass_bit <= 1'b0;
    else if (tck_rise && state == ST_SH_DR)
      bypass_bit <= link_s.tdi;
  end

  // shared 32-bit path for identification, user code and probe
  always_ff @(posedge clk)
  begin
    if (srst)
      dr32 <= '0;
    else if (tck_rise && state == ST_CAP_DR)
    begin
      unique case (sel)
        SEL_ID:
          dr32 <= {ID_VERSION, ID_PART, ID_MAKER, ID_FIXED_BIT};
        SEL_USER:
          dr32 <= usercode;
        SEL_PROBE:
          dr32 <= probe;
        default:
          dr32 <= dr32;
      endcase
    end
    else if (tck_rise && state == ST_SH_DR)
      dr32 <= {link_s.tdi, dr32[DR32_LEN-1:1]};
  end

  // boundary register; capture takes the pins in both sample and external test
  always_ff @(posedge clk)
  begin
    if (srst)
      bsr_shift <= '0;
    else if (tck_rise && sel == SEL_BSR && state == ST_CAP_DR)
      bsr_shift <= pin_s;
    else if (tck_rise && sel == SEL_BSR && state == ST_SH_DR)
      bsr_shift <= {link_s.tdi, bsr_shift[BSR_LEN-1:1]};
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      bsr_update <= '0;
    else if (tck_rise && sel == SEL_BSR && state == ST_UPD_DR)
      bsr_update <= bsr_shift;
  end

  // pins follow the core unless external test owns them
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      extest_active <= 1'b0;
      pin_out <= '0;
    end
    else
    begin
      extest_active <= (instr == OP_EXTEST) && boundary_ok;
      if ((instr == OP_EXTEST) && boundary_ok)
        pin_out <= bsr_update;
      else
        pin_out <= core_out;
    end
  end

  // configuration loader sees each shifted bit once
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cfg_bit <= 1'b0;
      cfg_bit_valid <= 1'b0;
    end
    else
    begin
      cfg_bit_valid <= tck_rise && sel == SEL_CFG && state == ST_SH_DR;
      if (tck_rise && sel == SEL_CFG && state == ST_SH_DR)
        cfg_bit <= link_s.tdi;
    end
  end

  always_comb
  begin
    unique case (sel)
      SEL_BSR:
        serial_out = bsr_shift[0];
      SEL_ID, SEL_USER, SEL_PROBE:
        serial_out = dr32[0];
      default:
        serial_out = bypass_bit;
    endcase
  end

  // serial output changes on the falling test clock edge, as the far end samples just before the fall
  always_ff @(posedge clk)
  begin
    if (srst)
      link_out <= '0;
    else if (tck_fall)
    begin
      if (state == ST_SH_IR)
      begin
        link_out.tdo <= ir_shift[0];
        link_out.tdo_oe <= 1'b1;
      end
      else if (state == ST_SH_DR)
      begin
        link_out.tdo <= serial_out;
        link_out.tdo_oe <= 1'b1;
      end
      else
      begin
        link_out.tdo <= 1'b0;
        link_out.tdo_oe <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### test_bst_tap.sv
`timescale 1ns/1ps
`default_nettype none
module test_bst_tap;
  import bst_pkg::*;
  logic clk, srst, config_busy, extest_active, cfg_bit, cfg_bit_valid;
  logic [31:0] usercode, probe;
  logic [BSR_LEN-1:0] pin_in, core_out, pin_out, q, pat;
  logic [7:0] cfg_seen;
  bst_link_in_t link_in;
  bst_link_out_t link_out;
  int n_cfg, base, n_mismatch, compares;
  bst_tap uut (.clk(clk), .srst(srst), .link_in(link_in), .link_out(link_out),
    .config_busy(config_busy), .usercode(usercode), .probe(probe), .pin_in(pin_in),
    .core_out(core_out), .pin_out(pin_out), .extest_active(extest_active),
    .cfg_bit(cfg_bit), .cfg_bit_valid(cfg_bit_valid));
  bst_ctrl_model m (.link(link_in), .lo(link_out));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
    if (cfg_bit_valid === 1'b1)
    begin
      cfg_seen <= {cfg_bit, cfg_seen[7:1]};
      n_cfg <= n_cfg + 1;
    end
  task automatic check(input logic [BSR_LEN-1:0] got, input logic [BSR_LEN-1:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic t_reset();
    repeat (3) @(negedge clk);
    check(pin_out, '0);
    check(BSR_LEN'({link_out, extest_active, cfg_bit_valid}), '0);
  endtask
  task automatic t_words();
    m.reset_tap();
    m.dr(32, '0, q);
    check(q, BSR_LEN'({ID_VERSION, ID_PART, ID_MAKER, 1'b1}));
    @(posedge clk) usercode <= 32'hC3A50F96;
    m.ir(OP_USERCODE, q);
    check(q, BSR_LEN'(10'h001));
    m.dr(32, '0, q);
    check(q, BSR_LEN'(usercode));
    @(posedge clk) probe <= 32'h5A0FE1D2;
    m.ir(OP_PROBE, q);
    m.dr(32, '0, q);
    check(q, BSR_LEN'(probe));
  endtask
  // last pass: boundary code while configuring must fall back to one flop
  task automatic t_bypass();
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk) config_busy <= (i == 2);
      m.ir(i == 0 ? OP_BYPASS : i == 1 ? 10'h155 : OP_EXTEST, q);
      m.dr(8, BSR_LEN'(8'hB4), q);
      check(q, BSR_LEN'(8'h68));
      check(BSR_LEN'(extest_active), '0);
    end
    @(posedge clk) config_busy <= 1'b0;
  endtask
  task automatic t_cfg();
    m.ir(OP_CFG_LOAD, q);
    base = n_cfg;
    m.dr(8, BSR_LEN'(8'h3C), q);
    check(BSR_LEN'(n_cfg - base), BSR_LEN'(8));
    check(BSR_LEN'(cfg_seen), BSR_LEN'(8'h3C));
  endtask
  task automatic t_bsr();
    @(posedge clk) pin_in <= {97{12'h3C6}};
    @(posedge clk) core_out <= {97{12'h9E1}};
    pat = {97{12'h5B2}};
    m.ir(OP_SAMPLE, q);
    m.dr(BSR_LEN, pat, q);
    check(q, pin_in);
    check(pin_out, core_out);
    m.ir(OP_EXTEST, q);
    repeat (3) @(negedge clk);
    check(BSR_LEN'(extest_active), BSR_LEN'(1));
    check(pin_out, pat);
    m.dr(BSR_LEN, ~pat, q);
    check(q, pin_in);
    check(pin_out, ~pat);
    @(posedge clk) config_busy <= 1'b1;
    repeat (3) @(negedge clk);
    check(pin_out, core_out);
    @(posedge clk) config_busy <= 1'b0;
    m.reset_tap();
  endtask
  initial
  begin
    srst = 1'b1;
    {config_busy, usercode, probe, pin_in, core_out} = '0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_words();
    t_bypass();
    t_cfg();
    t_bsr();
    end_sim();
  end
  initial
  begin
    #600000;
    n_mismatch++;
    end_sim();
  end
endmodule
bind bst_tap bst_props chk (.clk(clk), .srst(srst), .link_in(link_in), .link_out(link_out),
  .config_busy(config_busy), .core_out(core_out), .pin_out(pin_out),
  .extest_active(extest_active), .cfg_bit(cfg_bit), .cfg_bit_valid(cfg_bit_valid));
`default_nettype wire
